// ==== sbc_ctrl_cfg.svh ====
/*
 * Constants of the watchdog and bus mode control register bank: SPI frame
 * layout, register addresses, field positions, reset, restart and fail-safe
 * values.
 * Assumes a 16-bit SPI frame sent LSB first and an SBC state machine
 * outside that reports mode entries as one-cycle pulses.
 */
`ifndef SBC_CTRL_CFG_SVH
`define SBC_CTRL_CFG_SVH

// ============================================================================
// SPI frame
// ============================================================================
`define FRAME_LEN        16
`define FRAME_CNT_W      5
`define FRAME_ADDR_MSB   6
`define FRAME_WRITE_BIT  7
`define FRAME_DATA_LSB   8
`define FRAME_DATA_MSB   15

// ============================================================================
// Register addresses
// ============================================================================
`define ADDR_WATCHDOG    7'h03
`define ADDR_BUS_A       7'h04
`define ADDR_BUS_B       7'h05

// ============================================================================
// Watchdog control register
// ============================================================================
`define WD_CHECKSUM_BIT  7
`define WD_STOP_DIS_BIT  6
`define WD_TYPE_BIT      5
`define WD_BUS_WAKE_BIT  4
`define WD_PERIOD_MSB    2
`define WD_WRITE_MASK    8'hF7
`define WD_POR_VALUE     8'h14
`define WD_RESTART_LOW   4'h4

// ============================================================================
// Bus transceiver control register A
// ============================================================================
`define BUSA_FLASH_BIT   7
`define BUSA_SLOPE_BIT   6
`define BUSA_TXD_TO_BIT  5
`define BUSA_LIN_MSB     4
`define BUSA_LIN_LSB     3
`define BUSA_SWK_BIT     2
`define BUSA_CAN_MSB     1
`define BUSA_POR_VALUE   8'h20

// ============================================================================
// Bus transceiver control register B
// ============================================================================
`define BUSB_PEAK_BIT    5
`define BUSB_LIN_MSB     1
`define BUSB_WRITE_MASK  8'h23
`define BUSB_POR_VALUE   8'h00
`define BUSB_FS_VALUE    8'h01

// ============================================================================
// Transceiver mode codes
// ============================================================================
`define TRX_WAKE         2'h1
`define TRX_RX_ONLY      2'h2
`define TRX_NORMAL       2'h3

`endif

// ==== sbc_ctrl_pkg.sv ====
/*
 * Types shared by the SPI frame shifter and the control register bank.
 * Assumes the constants header is compiled alongside.
 */
package sbc_ctrl_pkg;

	// SBC operating mode as reported by the state machine outside.
	typedef enum logic [3:0]
	{
		SBC_INIT   = 4'h1,
		SBC_NORMAL = 4'h2,
		SBC_STOP   = 4'h4,
		SBC_OTHER  = 4'h8
	} sbc_mode_t;

	// Frame receiver state.
	typedef enum logic [1:0]
	{
		FRM_IDLE  = 2'h1,
		FRM_SHIFT = 2'h2
	} frame_state_t;

	typedef logic [1:0] trx_mode_t;

endpackage

// ==== spi_frame_shifter.sv ====
/*
 * SPI slave frame shifter: synchronises the SPI pins, shifts a 16-bit frame
 * in LSB first on rising clock edges and out on falling edges.
 * Assumes SPI mode 0 and a serial clock well below a quarter of the system
 * clock, so every pin edge is seen after synchronisation.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_ctrl_cfg.svh"

module spi_frame_shifter
(
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// SPI pins.
	input  wire logic                       sclk_i,
	input  wire logic                       sdi_i,
	input  wire logic                       cs_n_i,
	output logic                            sdo_o,
	// Frame side.
	input  wire logic [`FRAME_LEN-1:0]      tx_word_i,
	output logic [`FRAME_LEN-1:0]           frame_o,
	output logic                            frame_valid_o
);

	sbc_ctrl_pkg::frame_state_t state_reg, state_next;
	logic [2:0]                 sync1_reg, sync2_reg, sync3_reg;
	logic [`FRAME_LEN-1:0]      rx_reg, rx_next, tx_reg, tx_next;
	logic [`FRAME_CNT_W-1:0]    cnt_reg, cnt_next;
	logic                       sdo_reg, sdo_next, valid_reg, valid_next;
	logic                       sclk_rise, sclk_fall, cs_fall, cs_rise;

	// ========================================================================
	// Pin synchronisers: bit 0 clock, bit 1 data, bit 2 chip select.
	// ========================================================================
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= 3'h4;
			sync2_reg <= 3'h4;
			sync3_reg <= 3'h4;
		end
		else
		begin
			sync1_reg <= {cs_n_i, sdi_i, sclk_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign sclk_rise = sync2_reg[0] & ~sync3_reg[0];
	assign sclk_fall = ~sync2_reg[0] & sync3_reg[0];
	assign cs_fall   = ~sync2_reg[2] & sync3_reg[2];
	assign cs_rise   = sync2_reg[2] & ~sync3_reg[2];

	// ========================================================================
	// Frame shifting.
	// ========================================================================
	always_comb
	begin
		state_next = state_reg;
		rx_next    = rx_reg;
		tx_next    = tx_reg;
		cnt_next   = cnt_reg;
		sdo_next   = sdo_reg;
		valid_next = 1'b0;
		case (state_reg)
			sbc_ctrl_pkg::FRM_IDLE:
			begin
				sdo_next = 1'b0;
				if (cs_fall)
				begin
					state_next = sbc_ctrl_pkg::FRM_SHIFT;
					tx_next    = tx_word_i;
					sdo_next   = tx_word_i[0];
					cnt_next   = '0;
				end
			end
			sbc_ctrl_pkg::FRM_SHIFT:
			begin
				if (cs_rise)
				begin
					state_next = sbc_ctrl_pkg::FRM_IDLE;
					valid_next = (cnt_reg == `FRAME_CNT_W'(`FRAME_LEN));
					sdo_next   = 1'b0;
				end
				else if (sclk_rise)
				begin
					rx_next = {sync2_reg[1], rx_reg[`FRAME_LEN-1:1]};
					if (cnt_reg <= `FRAME_CNT_W'(`FRAME_LEN))
						cnt_next = cnt_reg + 1'b1;
				end
				else if (sclk_fall)
				begin
					tx_next  = {1'b0, tx_reg[`FRAME_LEN-1:1]};
					sdo_next = tx_reg[1];
				end
			end
			default:
				state_next = sbc_ctrl_pkg::FRM_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= sbc_ctrl_pkg::FRM_IDLE;
			rx_reg    <= '0;
			tx_reg    <= '0;
			cnt_reg   <= '0;
			sdo_reg   <= 1'b0;
			valid_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			rx_reg    <= rx_next;
			tx_reg    <= tx_next;
			cnt_reg   <= cnt_next;
			sdo_reg   <= sdo_next;
			valid_reg <= valid_next;
		end
	end

	assign sdo_o         = sdo_reg;
	assign frame_o       = rx_reg;
	assign frame_valid_o = valid_reg;

endmodule
`default_nettype wire

// ==== sbc_bus_mode_regs.sv ====
/*
 * Watchdog control and bus transceiver control registers of the system
 * basis chip, reached over the 16-bit SPI, with the automatic mode changes
 * on Sleep, restart, fail-safe and soft reset; Stop entry changes nothing.
 * Assumes the SBC state machine drives the event pulses and the mode code
 * on the same clock, and that the watchdog and transceiver logic consume
 * the field outputs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbc_ctrl_cfg.svh"

module sbc_bus_mode_regs
(
	// Clock and reset.
	input  wire logic                    REF_CLK_I,
	input  wire logic                    RST_I,
	// SPI pins.
	input  wire logic                    SCLK_I,
	input  wire logic                    SDI_I,
	input  wire logic                    SERIAL_CHIP_SELECT_N_I,
	output logic                         SDO_O,
	// SBC state machine.
	input  wire sbc_ctrl_pkg::sbc_mode_t SBC_MODE_I,
	input  wire logic                    SYSTEM_ERROR_FLAG_I,
	input  wire logic                    SLEEP_ENTRY_I,
	input  wire logic                    STOP_ENTRY_I,
	input  wire logic                    RESTART_ENTRY_I,
	input  wire logic                    FAILSAFE_ENTRY_I,
	input  wire logic                    SOFT_RESET_I,
	// Transceiver modes chosen by the cause of a restart.
	input  wire logic [1:0]              RESTART_FIRST_LIN_I,
	input  wire logic [1:0]              RESTART_CAN_I,
	input  wire logic [1:0]              RESTART_SECOND_LIN_I,
	// Hardware updates of the device-writable fields.
	input  wire logic                    TRX_UPDATE_I,
	input  wire logic [1:0]              TRX_FIRST_LIN_I,
	input  wire logic [1:0]              TRX_CAN_I,
	input  wire logic [1:0]              TRX_SECOND_LIN_I,
	input  wire logic                    WD_UPDATE_I,
	input  wire logic                    WD_STOP_DISABLE_I,
	input  wire logic [2:0]              WD_PERIOD_I,
	// Watchdog settings.
	output logic                         WATCHDOG_STOP_DISABLE_LO_O,
	output logic                         WATCHDOG_TYPE_SELECT_O,
	output logic                         WATCHDOG_START_ON_BUS_WAKE_O,
	output logic [2:0]                   WATCHDOG_PERIOD_SELECT_O,
	output logic                         WATCHDOG_CHECKSUM_OK_O,
	// Bus transceiver settings.
	output logic                         LIN_FLASH_MODE_O,
	output logic                         LIN_LOW_SLOPE_SELECT_O,
	output logic                         LIN_TRANSMIT_TIMEOUT_ENABLE_O,
	output logic [1:0]                   FIRST_LIN_MODE_O,
	output logic                         SELECTIVE_WAKE_O,
	output logic [1:0]                   CAN_MODE_O,
	output logic                         SUPPLY_PEAK_THRESHOLD_SELECT_O,
	output logic [1:0]                   SECOND_LIN_MODE_O,
	// Request to restore the external wake register defaults.
	output logic                         FAILSAFE_WAKE_DEFAULTS_O
);

	logic [`FRAME_LEN-1:0] frame;
	logic                  frame_valid;
	logic [6:0]            addr;
	logic                  write_en;
	logic [7:0]            wdata, rdata;
	logic                  peak_writable;

	logic [7:0]            wd_reg, wd_next;
	logic [7:0]            bus_a_reg, bus_a_next;
	logic [7:0]            bus_b_reg, bus_b_next;
	logic [`FRAME_LEN-1:0] tx_reg, tx_next;
	logic                  chk_reg, chk_next;
	logic                  wake_def_reg, wake_def_next;

	// ========================================================================
	// SPI frame shifter.
	// ========================================================================
	spi_frame_shifter u_shifter
	(
		.clk_i         (REF_CLK_I),
		.rst_i         (RST_I),
		.sclk_i        (SCLK_I),
		.sdi_i         (SDI_I),
		.cs_n_i        (SERIAL_CHIP_SELECT_N_I),
		.sdo_o         (SDO_O),
		.tx_word_i     (tx_reg),
		.frame_o       (frame),
		.frame_valid_o (frame_valid)
	);

	assign addr     = frame[`FRAME_ADDR_MSB:0];
	assign write_en = frame_valid & frame[`FRAME_WRITE_BIT];
	assign wdata    = frame[`FRAME_DATA_MSB:`FRAME_DATA_LSB];
	assign peak_writable = (SBC_MODE_I == sbc_ctrl_pkg::SBC_INIT) |
		(SBC_MODE_I == sbc_ctrl_pkg::SBC_NORMAL);

	// Read data of the addressed register before any write in this frame.
	always_comb
	begin
		case (addr)
			`ADDR_WATCHDOG: rdata = wd_reg;
			`ADDR_BUS_A:    rdata = bus_a_reg;
			`ADDR_BUS_B:    rdata = bus_b_reg;
			default:        rdata = 8'h00;
		endcase
	end

	// ========================================================================
	// Register next values, lowest priority first.
	// ========================================================================
	always_comb
	begin
		wd_next       = wd_reg;
		bus_a_next    = bus_a_reg;
		bus_b_next    = bus_b_reg;
		tx_next       = tx_reg;
		wake_def_next = 1'b0;

		// Frames commit only when chip select returns high.
		if (frame_valid)
			tx_next = {rdata, 8'h00};
		if (write_en)
		begin
			case (addr)
				`ADDR_WATCHDOG:
					wd_next = wdata & `WD_WRITE_MASK;
				`ADDR_BUS_A:
					bus_a_next = wdata;
				`ADDR_BUS_B:
				begin
					bus_b_next = wdata & `BUSB_WRITE_MASK;
					if (!peak_writable)
						bus_b_next[`BUSB_PEAK_BIT] =
							bus_b_reg[`BUSB_PEAK_BIT];
				end
				default:
					bus_b_next = bus_b_reg;
			endcase
		end

		// Hardware updates never touch the selective wake bit.
		if (TRX_UPDATE_I)
		begin
			bus_a_next[`BUSA_LIN_MSB:`BUSA_LIN_LSB] = TRX_FIRST_LIN_I;
			bus_a_next[`BUSA_CAN_MSB:0] = TRX_CAN_I;
			bus_b_next[`BUSB_LIN_MSB:0] = TRX_SECOND_LIN_I;
		end
		if (WD_UPDATE_I)
		begin
			wd_next[`WD_STOP_DIS_BIT] = WD_STOP_DISABLE_I;
			wd_next[`WD_PERIOD_MSB:0] = WD_PERIOD_I;
		end

		// Stop entry leaves receive only in place, so only Sleep acts.
		if (SLEEP_ENTRY_I && !SYSTEM_ERROR_FLAG_I)
		begin
			if ((bus_a_reg[`BUSA_CAN_MSB:0] == `TRX_NORMAL) ||
				(bus_a_reg[`BUSA_CAN_MSB:0] == `TRX_RX_ONLY))
				bus_a_next[`BUSA_CAN_MSB:0] = `TRX_WAKE;
		end

		if (RESTART_ENTRY_I)
		begin
			wd_next = {wd_reg[`WD_CHECKSUM_BIT], 1'b0,
				wd_reg[`WD_TYPE_BIT:`WD_BUS_WAKE_BIT],
				`WD_RESTART_LOW};
			bus_a_next = {bus_a_reg[`BUSA_FLASH_BIT:`BUSA_TXD_TO_BIT],
				RESTART_FIRST_LIN_I, bus_a_reg[`BUSA_SWK_BIT],
				RESTART_CAN_I};
			bus_b_next = `BUSB_POR_VALUE;
			bus_b_next[`BUSB_PEAK_BIT] = bus_b_reg[`BUSB_PEAK_BIT];
			bus_b_next[`BUSB_LIN_MSB:0] = RESTART_SECOND_LIN_I;
		end

		// Fail-safe leaves the wake sources armed.
		if (FAILSAFE_ENTRY_I)
		begin
			bus_a_next = {bus_a_reg[`BUSA_FLASH_BIT:`BUSA_TXD_TO_BIT],
				`TRX_WAKE, bus_a_reg[`BUSA_SWK_BIT], `TRX_WAKE};
			bus_b_next    = `BUSB_FS_VALUE;
			wake_def_next = 1'b1;
		end

		if (SOFT_RESET_I)
		begin
			wd_next    = `WD_POR_VALUE;
			bus_a_next = `BUSA_POR_VALUE;
			bus_b_next = `BUSB_POR_VALUE;
		end

		// The top bit only serves as a parity check on the settings.
		chk_next = ~^wd_next;
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			wd_reg       <= `WD_POR_VALUE;
			bus_a_reg    <= `BUSA_POR_VALUE;
			bus_b_reg    <= `BUSB_POR_VALUE;
			tx_reg       <= '0;
			chk_reg      <= ~^`WD_POR_VALUE;
			wake_def_reg <= 1'b0;
		end
		else
		begin
			wd_reg       <= wd_next;
			bus_a_reg    <= bus_a_next;
			bus_b_reg    <= bus_b_next;
			tx_reg       <= tx_next;
			chk_reg      <= chk_next;
			wake_def_reg <= wake_def_next;
		end
	end

	// ========================================================================
	// Field outputs, taken straight from the registers.
	// ========================================================================
	assign WATCHDOG_STOP_DISABLE_LO_O     = wd_reg[`WD_STOP_DIS_BIT];
	assign WATCHDOG_TYPE_SELECT_O         = wd_reg[`WD_TYPE_BIT];
	assign WATCHDOG_START_ON_BUS_WAKE_O   = wd_reg[`WD_BUS_WAKE_BIT];
	assign WATCHDOG_PERIOD_SELECT_O       = wd_reg[`WD_PERIOD_MSB:0];
	assign WATCHDOG_CHECKSUM_OK_O         = chk_reg;
	assign LIN_FLASH_MODE_O               = bus_a_reg[`BUSA_FLASH_BIT];
	assign LIN_LOW_SLOPE_SELECT_O         = bus_a_reg[`BUSA_SLOPE_BIT];
	assign LIN_TRANSMIT_TIMEOUT_ENABLE_O  = bus_a_reg[`BUSA_TXD_TO_BIT];
	assign FIRST_LIN_MODE_O = bus_a_reg[`BUSA_LIN_MSB:`BUSA_LIN_LSB];
	assign SELECTIVE_WAKE_O               = bus_a_reg[`BUSA_SWK_BIT];
	assign CAN_MODE_O                     = bus_a_reg[`BUSA_CAN_MSB:0];
	assign SUPPLY_PEAK_THRESHOLD_SELECT_O = bus_b_reg[`BUSB_PEAK_BIT];
	assign SECOND_LIN_MODE_O              = bus_b_reg[`BUSB_LIN_MSB:0];
	assign FAILSAFE_WAKE_DEFAULTS_O       = wake_def_reg;

endmodule
`default_nettype wire

// ==== sbc_bus_mode_regs_chk.sv ====
/*
 * Checker of the watchdog and bus mode register bank.
 * Assumes it is bound to the bank and sees only the bank's ports.
 */
`timescale 1ns/100ps
`default_nettype none

module sbc_bus_mode_regs_chk
(
	// Clock, reset and chip select.
	input wire logic                    REF_CLK_I,
	input wire logic                    RST_I,
	input wire logic                    SERIAL_CHIP_SELECT_N_I,
	// State machine events.
	input wire sbc_ctrl_pkg::sbc_mode_t SBC_MODE_I,
	input wire logic                    SYSTEM_ERROR_FLAG_I,
	input wire logic                    SLEEP_ENTRY_I,
	input wire logic                    STOP_ENTRY_I,
	input wire logic                    RESTART_ENTRY_I,
	input wire logic                    FAILSAFE_ENTRY_I,
	input wire logic                    SOFT_RESET_I,
	input wire logic [1:0]              RESTART_FIRST_LIN_I,
	input wire logic [1:0]              RESTART_CAN_I,
	input wire logic [1:0]              RESTART_SECOND_LIN_I,
	input wire logic                    TRX_UPDATE_I,
	// Register fields.
	input wire logic                    WATCHDOG_STOP_DISABLE_LO_O,
	input wire logic                    WATCHDOG_TYPE_SELECT_O,
	input wire logic                    WATCHDOG_START_ON_BUS_WAKE_O,
	input wire logic [2:0]              WATCHDOG_PERIOD_SELECT_O,
	input wire logic                    LIN_FLASH_MODE_O,
	input wire logic                    LIN_LOW_SLOPE_SELECT_O,
	input wire logic                    LIN_TRANSMIT_TIMEOUT_ENABLE_O,
	input wire logic [1:0]              FIRST_LIN_MODE_O,
	input wire logic                    SELECTIVE_WAKE_O,
	input wire logic [1:0]              CAN_MODE_O,
	input wire logic                    SUPPLY_PEAK_THRESHOLD_SELECT_O,
	input wire logic [1:0]              SECOND_LIN_MODE_O,
	input wire logic                    FAILSAFE_WAKE_DEFAULTS_O
);
	// ========================================================================
	// Cycles since chip select was last seen low
	// ========================================================================
	logic [3:0] age_reg;
	logic [3:0] age_next;
	logic       calm;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	// A frame commits within a few cycles of chip select rising.
	always_comb
	begin
		age_next = age_reg;
		if (!SERIAL_CHIP_SELECT_N_I)
			age_next = 4'h0;
		else if (age_reg != 4'hF)
			age_next = age_reg + 4'h1;
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I)
		if (RST_I)
			age_reg <= 4'hF;
		else
			age_reg <= age_next;

	assign calm = !(RESTART_ENTRY_I || FAILSAFE_ENTRY_I || SOFT_RESET_I);

	// ========================================================================
	// Properties
	// ========================================================================
	property p_swk_host_only;
		!$stable(SELECTIVE_WAKE_O) |-> $past(SOFT_RESET_I) || age_reg < 4'h8;
	endproperty
	a_swk_host_only: assert property (p_swk_host_only)
		else $error("selective wake changed without a host write");

	property p_slope_on_cs;
		!$stable({LIN_FLASH_MODE_O, LIN_LOW_SLOPE_SELECT_O,
			LIN_TRANSMIT_TIMEOUT_ENABLE_O}) |->
			$past(SOFT_RESET_I) || age_reg < 4'h8;
	endproperty
	a_slope_on_cs: assert property (p_slope_on_cs)
		else $error("slope bits changed away from a frame end");

	property p_sleep_can;
		SLEEP_ENTRY_I && !SYSTEM_ERROR_FLAG_I && calm && CAN_MODE_O[1]
			|=> CAN_MODE_O == 2'h1;
	endproperty
	a_sleep_can: assert property (p_sleep_can)
		else $error("sleep entry did not make the CAN wake capable");

	property p_can_kept;
		(STOP_ENTRY_I || SLEEP_ENTRY_I && SYSTEM_ERROR_FLAG_I) && calm &&
			!TRX_UPDATE_I && age_reg > 4'h7 |=> $stable(CAN_MODE_O);
	endproperty
	a_can_kept: assert property (p_can_kept)
		else $error("CAN mode changed on stop entry");

	property p_restart_wd;
		RESTART_ENTRY_I && !SOFT_RESET_I && age_reg > 4'h7 |=>
			WATCHDOG_PERIOD_SELECT_O == 3'h4 && !WATCHDOG_STOP_DISABLE_LO_O &&
			$stable({WATCHDOG_TYPE_SELECT_O, WATCHDOG_START_ON_BUS_WAKE_O});
	endproperty
	a_restart_wd: assert property (p_restart_wd)
		else $error("watchdog restart value wrong");

	property p_restart_bus;
		RESTART_ENTRY_I && !FAILSAFE_ENTRY_I && !SOFT_RESET_I &&
			age_reg > 4'h7 |=> FIRST_LIN_MODE_O == $past(RESTART_FIRST_LIN_I) &&
			CAN_MODE_O == $past(RESTART_CAN_I) &&
			SECOND_LIN_MODE_O == $past(RESTART_SECOND_LIN_I) &&
			$stable(SUPPLY_PEAK_THRESHOLD_SELECT_O);
	endproperty
	a_restart_bus: assert property (p_restart_bus)
		else $error("bus restart value wrong");

	property p_failsafe;
		FAILSAFE_ENTRY_I && !SOFT_RESET_I |=> !SUPPLY_PEAK_THRESHOLD_SELECT_O &&
			{FIRST_LIN_MODE_O, CAN_MODE_O, SECOND_LIN_MODE_O} == 6'h15;
	endproperty
	a_failsafe: assert property (p_failsafe)
		else $error("fail-safe values wrong");

	property p_wake_pulse;
		FAILSAFE_WAKE_DEFAULTS_O == $past(FAILSAFE_ENTRY_I);
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake defaults pulse wrong");

	property p_soft_reset;
		SOFT_RESET_I |=> {WATCHDOG_STOP_DISABLE_LO_O, WATCHDOG_TYPE_SELECT_O,
			WATCHDOG_START_ON_BUS_WAKE_O, WATCHDOG_PERIOD_SELECT_O} == 6'h0C &&
			{LIN_FLASH_MODE_O, LIN_LOW_SLOPE_SELECT_O,
			LIN_TRANSMIT_TIMEOUT_ENABLE_O, FIRST_LIN_MODE_O, SELECTIVE_WAKE_O,
			CAN_MODE_O, SUPPLY_PEAK_THRESHOLD_SELECT_O,
			SECOND_LIN_MODE_O} == 11'h100;
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("soft reset values wrong");

	property p_peak_mode;
		$rose(SUPPLY_PEAK_THRESHOLD_SELECT_O) |-> SBC_MODE_I inside
			{sbc_ctrl_pkg::SBC_INIT, sbc_ctrl_pkg::SBC_NORMAL};
	endproperty
	a_peak_mode: assert property (p_peak_mode)
		else $error("peak threshold set outside init or normal");
endmodule

bind sbc_bus_mode_regs sbc_bus_mode_regs_chk i_sbc_bus_mode_regs_chk
(
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
	.SERIAL_CHIP_SELECT_N_I(SERIAL_CHIP_SELECT_N_I), .SBC_MODE_I(SBC_MODE_I),
	.SYSTEM_ERROR_FLAG_I(SYSTEM_ERROR_FLAG_I), .SLEEP_ENTRY_I(SLEEP_ENTRY_I),
	.STOP_ENTRY_I(STOP_ENTRY_I), .RESTART_ENTRY_I(RESTART_ENTRY_I),
	.FAILSAFE_ENTRY_I(FAILSAFE_ENTRY_I), .SOFT_RESET_I(SOFT_RESET_I),
	.RESTART_FIRST_LIN_I(RESTART_FIRST_LIN_I), .RESTART_CAN_I(RESTART_CAN_I),
	.RESTART_SECOND_LIN_I(RESTART_SECOND_LIN_I), .TRX_UPDATE_I(TRX_UPDATE_I),
	.WATCHDOG_STOP_DISABLE_LO_O(WATCHDOG_STOP_DISABLE_LO_O),
	.WATCHDOG_TYPE_SELECT_O(WATCHDOG_TYPE_SELECT_O),
	.WATCHDOG_START_ON_BUS_WAKE_O(WATCHDOG_START_ON_BUS_WAKE_O),
	.WATCHDOG_PERIOD_SELECT_O(WATCHDOG_PERIOD_SELECT_O),
	.LIN_FLASH_MODE_O(LIN_FLASH_MODE_O),
	.LIN_LOW_SLOPE_SELECT_O(LIN_LOW_SLOPE_SELECT_O),
	.LIN_TRANSMIT_TIMEOUT_ENABLE_O(LIN_TRANSMIT_TIMEOUT_ENABLE_O),
	.FIRST_LIN_MODE_O(FIRST_LIN_MODE_O), .SELECTIVE_WAKE_O(SELECTIVE_WAKE_O),
	.CAN_MODE_O(CAN_MODE_O),
	.SUPPLY_PEAK_THRESHOLD_SELECT_O(SUPPLY_PEAK_THRESHOLD_SELECT_O),
	.SECOND_LIN_MODE_O(SECOND_LIN_MODE_O),
	.FAILSAFE_WAKE_DEFAULTS_O(FAILSAFE_WAKE_DEFAULTS_O)
);

`default_nettype wire

// ==== spi_host_model.sv ====
/*
 * Host side of the SPI: a mode 0 master sending one frame LSB first.
 * Assumes the bank's system clock, used only to pace the pins.
 */
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
(
	// Pacing clock.
	input  wire logic clk_i,
	// SPI pins.
	output logic      sclk_o,
	output logic      sdi_o,
	output logic      cs_n_o,
	input  wire logic sdo_i
);
	initial
	begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		cs_n_o = 1'b1;
	end

	task automatic pace(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Bit counts other than 16 are sent only to have a frame refused.
	task automatic xfer(input logic [15:0] w, input int nbits,
		output logic [15:0] r);
		r = 16'h0000;
		pace(1);
		cs_n_o = 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			sdi_o = w[i];
			pace(5);
			sclk_o = 1'b1;
			r[i] = sdo_i;
			pace(5);
			sclk_o = 1'b0;
		end
		pace(5);
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		pace(6);
	endtask
endmodule

`default_nettype wire

// ==== watchdog_and_bus_mode_control_regs_tb_top.sv ====
/*
 * Self-checking bench of the watchdog and bus mode register bank.
 * Assumes the SPI host model and the checker are compiled alongside.
 */
`timescale 1ns/100ps
`default_nettype none

module watchdog_and_bus_mode_control_regs_tb_top;
	typedef struct packed
	{
		logic        is_read;
		logic [18:0] val;
	} note_t;

	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    sclk, sdi, cs_n, sdo, fs_wake, rd_ok;
	sbc_ctrl_pkg::sbc_mode_t mode = sbc_ctrl_pkg::SBC_INIT;
	logic                    system_error_flag = 1'b0;
	logic [6:0]              ev = 7'h00;
	logic [5:0]              rmode = 6'h00;
	logic [5:0]              tmode = 6'h00;
	logic [3:0]              wdv = 4'h0;
	logic [17:0]             outs;
	logic [7:0]              wd, ba, bb, rd_pend;
	logic [15:0]             rword;
	logic [31:0]             r, d;
	note_t                   n;
	note_t                   notes[$];
	event                    look;
	integer                  seed = 32'hA36749EF;
	int                      failures = 0;
	int                      num_checks = 0;

	always #5 clk = ~clk;

	// ev: sleep, stop, restart, fail-safe, soft reset, trx and wd updates.
	sbc_bus_mode_regs i_sbc_bus_mode_regs
	(
		.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .SDI_I(sdi),
		.SERIAL_CHIP_SELECT_N_I(cs_n), .SDO_O(sdo), .SBC_MODE_I(mode),
		.SYSTEM_ERROR_FLAG_I(system_error_flag), .SLEEP_ENTRY_I(ev[0]),
		.STOP_ENTRY_I(ev[1]), .RESTART_ENTRY_I(ev[2]),
		.FAILSAFE_ENTRY_I(ev[3]), .SOFT_RESET_I(ev[4]),
		.RESTART_FIRST_LIN_I(rmode[5:4]), .RESTART_CAN_I(rmode[3:2]),
		.RESTART_SECOND_LIN_I(rmode[1:0]), .TRX_UPDATE_I(ev[5]),
		.TRX_FIRST_LIN_I(tmode[5:4]), .TRX_CAN_I(tmode[3:2]),
		.TRX_SECOND_LIN_I(tmode[1:0]), .WD_UPDATE_I(ev[6]),
		.WD_STOP_DISABLE_I(wdv[3]), .WD_PERIOD_I(wdv[2:0]),
		.WATCHDOG_STOP_DISABLE_LO_O(outs[17]),
		.WATCHDOG_TYPE_SELECT_O(outs[16]),
		.WATCHDOG_START_ON_BUS_WAKE_O(outs[15]),
		.WATCHDOG_PERIOD_SELECT_O(outs[14:12]),
		.WATCHDOG_CHECKSUM_OK_O(outs[11]), .LIN_FLASH_MODE_O(outs[10]),
		.LIN_LOW_SLOPE_SELECT_O(outs[9]),
		.LIN_TRANSMIT_TIMEOUT_ENABLE_O(outs[8]),
		.FIRST_LIN_MODE_O(outs[7:6]), .SELECTIVE_WAKE_O(outs[5]),
		.CAN_MODE_O(outs[4:3]), .SUPPLY_PEAK_THRESHOLD_SELECT_O(outs[2]),
		.SECOND_LIN_MODE_O(outs[1:0]), .FAILSAFE_WAKE_DEFAULTS_O(fs_wake)
	);

	spi_host_model i_spi_host_model
	(
		.clk_i(clk), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n), .sdo_i(sdo)
	);

	// ========================================================================
	// Reference model and drivers
	// ========================================================================
	function automatic logic [18:0] outs_exp(input logic fs);
		return {wd[6:4], wd[2:0], ~^wd, ba, bb[5], bb[1:0], fs};
	endfunction

	task automatic pace(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic note(input logic rd, input logic [18:0] v);
		notes.push_back({rd, v});
		-> look;
	endtask

	task automatic spi(input logic [6:0] adr, input logic w,
		input logic [7:0] dt, input int nb);
		logic [7:0] old;
		old = (adr == 7'h03) ? wd : (adr == 7'h04) ? ba :
			(adr == 7'h05) ? bb : 8'h00;
		i_spi_host_model.xfer({dt, w, adr}, nb, rword);
		if (rd_ok)
			note(1'b1, {11'h000, rd_pend & {nb == 16, 7'h7F}});
		rd_ok = (nb == 16);
		rd_pend = old;
		if (nb == 16 && w)
			case (adr)
				7'h03: wd = dt & 8'hF7;
				7'h04: ba = dt;
				7'h05: bb = {2'h0, (mode == sbc_ctrl_pkg::SBC_INIT ||
					mode == sbc_ctrl_pkg::SBC_NORMAL) ? dt[5] : bb[5],
					3'h0, dt[1:0]};
				default: ;
			endcase
		pace(2);
		note(1'b0, outs_exp(1'b0));
	endtask

	task automatic pulse(input int k);
		ev[k] = 1'b1;
		pace(1);
		ev = 7'h00;
		case (k)
			0: if (!system_error_flag && ba[1]) ba[1:0] = 2'h1;
			2: {wd, ba, bb} = {wd[7], 1'b0, wd[5:4], 4'h4, ba[7:5],
				rmode[5:4], ba[2], rmode[3:2], 2'h0, bb[5], 3'h0,
				rmode[1:0]};
			3: {ba, bb} = {ba[7:5], 2'h1, ba[2], 2'h1, 8'h01};
			4: {wd, ba, bb} = 24'h142000;
			5: {ba[4:3], ba[1:0], bb[1:0]} = tmode;
			6: {wd[6], wd[2:0]} = wdv;
			default: ;
		endcase
		note(1'b0, outs_exp(k == 3));
		pace(2);
	endtask

	// ========================================================================
	// Result watcher and verdict
	// ========================================================================
	task automatic check(input string what, input logic [18:0] seen,
		input logic [18:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	always @(look)
	begin
		n = notes.pop_front();
		if (n.is_read)
			check("read data", {11'h000, rword[15:8]}, n.val);
		else
			check("outputs", {outs, fs_wake}, n.val);
	end

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial
	begin
		{wd, ba, bb} = 24'h142000;
		rd_ok = 1'b0;
		pace(6);
		rst = 1'b0;
		pace(2);
		note(1'b0, outs_exp(1'b0));
		for (int i = 0; i < 8; i++)
		begin
			r = $random(seed);
			spi(7'h03, 1'b1, {^{r[6:4], i[2:0]}, r[6:4], 1'b0, i[2:0]}, 16);
			spi(7'h04, 1'b1, {r[2:0], i[1:0], i[2:0]}, 16);
			spi(7'h05, 1'b1, {2'h3, r[7], 3'h7, i[1:0]}, 16);
			pulse(1);
			system_error_flag = r[8];
			pulse(0);
		end
		rst = 1'b1;
		pace(2);
		rst = 1'b0;
		{wd, ba, bb} = 24'h142000;
		rd_ok = 1'b0;
		pace(2);
		note(1'b0, outs_exp(1'b0));
		for (int i = 0; i < 60; i++)
		begin
			r = $random(seed);
			d = $random(seed);
			mode = sbc_ctrl_pkg::sbc_mode_t'(4'h1 << r[9:8]);
			system_error_flag = r[10];
			{rmode, tmode, wdv} = r[25:10];
			if (r[31:28] > 4'h6)
				spi(7'(r[2:0]), r[3], d[7:0], (r[27:26] == 2'h0) ? 15 : 16);
			else
				pulse(int'(r[31:28]));
		end
		spi(7'h00, 1'b0, 8'h00, 16);
		pace(4);
		complete_run();
	end
endmodule

`default_nettype wire
